// ### chan_irq_source.sv
`default_nettype none
// channel sources behind their own source_irq_enable, level requests
module chan_irq_source (
    input  wire logic [5:0] i_event,
    input  wire logic [5:0] i_source_irq_enable,
    output logic      [5:0] o_chan_irq
);
    timeunit 1ns / 1ns;
    assign o_chan_irq = i_event & i_source_irq_enable;
endmodule : chan_irq_source
`default_nettype wire

// ### channel_enable_irq_gate_regs.sv
`default_nettype none
module channel_enable_irq_gate_regs
    import liu_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // parallel register port
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata,
    // line controls, channels 0..5 in bits 0..5
    input  wire logic       i_tx_line_on_master,
    output logic      [5:0] o_tx_line_pos_out_oe_n,
    output logic      [5:0] o_tx_line_neg_out_oe_n,
    output logic      [5:0] o_rx_line_pos_in_oe_n,
    output logic      [5:0] o_rx_line_neg_in_oe_n,
    output logic      [5:0] o_tx_line_on,
    output logic      [5:0] o_rx_line_on,
    // interrupt gating, channels 0..5 already qualified by source_irq_enable
    input  wire logic [5:0] i_chan_irq,
    output logic            o_irq_n
);
    ////////////////////////////////////////////////////////////////////////
    // which register a request points at
    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_IRQ  = 2'b01,
        SEL_TX   = 2'b10,
        SEL_RX   = 2'b11
    } reg_sel_e;

    host_req_s  req;
    reg_sel_e   req_sel;
    ctrl_regs_s regs;
    ctrl_regs_s next_regs;
    logic       wr_irq;
    logic       wr_tx;
    logic       wr_rx;
    logic [7:0] next_rdata;
    logic [5:0] tx_drive;
    logic [5:0] tx_oe_n;
    logic [5:0] rx_oe_n;
    logic [5:0] next_tx_pos_oe_n;
    logic [5:0] next_tx_neg_oe_n;
    logic [5:0] next_rx_pos_oe_n;
    logic [5:0] next_rx_neg_oe_n;
    logic [5:0] next_tx_line_on;
    logic [5:0] next_rx_line_on;
    logic [5:0] irq_gated;
    logic       next_irq_n;

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // only the six live bits ever reach a register
    function automatic logic [5:0] pick(input logic [7:0] d);
        pick = d[5:0] & FIELD_MASK;
    endfunction : pick

    // full byte compare, so aliases of a mapped address stay unmapped
    function automatic reg_sel_e decode(input logic [7:0] a);
        unique case (a)
            ADDR_IRQ_MASTER: decode = SEL_IRQ;
            ADDR_TX_ON:      decode = SEL_TX;
            ADDR_RX_ON:      decode = SEL_RX;
            default:         decode = SEL_NONE;
        endcase
    endfunction : decode

    // reserved bits are not stored, so reads cannot echo them
    function automatic logic [5:0] field_of(input reg_sel_e s, input ctrl_regs_s r);
        unique case (s)
            SEL_IRQ:  field_of = r.irq_master;
            SEL_TX:   field_of = r.tx_on;
            SEL_RX:   field_of = r.rx_on;
            SEL_NONE: field_of = 6'h00;
        endcase
    endfunction : field_of

    always_comb begin
        req     = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};
        req_sel = decode(req.addr);
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers
    // one write strobe per register, at most one of them high
    always_comb begin
        wr_irq = req.wr && (req_sel == SEL_IRQ);
        wr_tx  = req.wr && (req_sel == SEL_TX);
        wr_rx  = req.wr && (req_sel == SEL_RX);
    end

    always_comb begin
        next_regs = regs;
        // unmapped writes touch nothing
        if (wr_irq) begin
            next_regs.irq_master = pick(req.wdata);
        end
        if (wr_tx) begin
            next_regs.tx_on = pick(req.wdata);
        end
        if (wr_rx) begin
            next_regs.rx_on = pick(req.wdata);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            regs <= '{tx_on: RST_TX_ON, rx_on: RST_RX_ON, irq_master: RST_IRQ_MASTER};
        end else begin
            regs <= next_regs;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data; a read in the cycle of a write still sees the old value
    // unmapped addresses and idle cycles read zero
    always_comb begin
        next_rdata = READ_UNMAPPED;
        if (req.rd) begin
            next_rdata = {2'b00, field_of(req_sel, regs)};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= READ_UNMAPPED;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel enables; the master pin gate sits in front of the flops
    line_gate u_line_gate (
        .i_tx_on     (regs.tx_on),
        .i_rx_on     (regs.rx_on),
        .i_tx_master (i_tx_line_on_master),
        .o_tx_drive  (tx_drive),
        .o_tx_oe_n   (tx_oe_n),
        .o_rx_oe_n   (rx_oe_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // transmit pins
    // both legs share one enable, so a pair never drives half a pulse
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_tx_pin
        assign next_tx_pos_oe_n[ch] = tx_oe_n[ch];
        assign next_tx_neg_oe_n[ch] = tx_oe_n[ch];
        assign next_tx_line_on[ch]  = tx_drive[ch];
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_line_pos_out_oe_n <= ~RST_TX_ON;
            o_tx_line_neg_out_oe_n <= ~RST_TX_ON;
            o_tx_line_on           <= RST_TX_ON;
        end else begin
            o_tx_line_pos_out_oe_n <= next_tx_pos_oe_n;
            o_tx_line_neg_out_oe_n <= next_tx_neg_oe_n;
            o_tx_line_on           <= next_tx_line_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive pins
    // a switched-off receiver floats both legs of its pair
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_rx_pin
        assign next_rx_pos_oe_n[ch] = rx_oe_n[ch];
        assign next_rx_neg_oe_n[ch] = rx_oe_n[ch];
        assign next_rx_line_on[ch]  = regs.rx_on[ch];
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_line_pos_in_oe_n <= ~RST_RX_ON;
            o_rx_line_neg_in_oe_n <= ~RST_RX_ON;
            o_rx_line_on          <= RST_RX_ON;
        end else begin
            o_rx_line_pos_in_oe_n <= next_rx_pos_oe_n;
            o_rx_line_neg_in_oe_n <= next_rx_neg_oe_n;
            o_rx_line_on          <= next_rx_line_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host interrupt; source enables are applied upstream
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_irq
        assign irq_gated[ch] = i_chan_irq[ch] & regs.irq_master[ch];
    end

    always_comb begin
        next_irq_n = ~|irq_gated;
    end

    // registered so a change of enable cannot glitch the host pin
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_n <= 1'b1;
        end else begin
            o_irq_n <= next_irq_n;
        end
    end
endmodule : channel_enable_irq_gate_regs
`default_nettype wire

// ### channel_enable_irq_gate_regs_monitor.sv
`default_nettype none
module channel_enable_irq_gate_regs_monitor
    import liu_ctrl_pkg::*;
(
    input wire logic       i_clk, i_rst_n, i_wr, i_rd, i_tx_line_on_master, o_irq_n,
    input wire logic [7:0] i_addr, i_wdata, o_rdata,
    input wire logic [5:0] i_chan_irq, o_tx_line_on, o_rx_line_on, o_tx_line_pos_out_oe_n,
    input wire logic [5:0] o_tx_line_neg_out_oe_n, o_rx_line_pos_in_oe_n, o_rx_line_neg_in_oe_n
);
    timeunit 1ns / 1ns;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // quiet cycle after the write so a later write cannot mask the value
    sequence wr_at(a); i_wr && i_addr == a ##1 !i_wr; endsequence
    chk_tx_gate: assert property (!i_tx_line_on_master |=> !o_tx_line_on)
        else $error("tx on, master low");
    chk_tx_oe_pair: assert property ({o_tx_line_pos_out_oe_n, o_tx_line_neg_out_oe_n}
        == {2{~o_tx_line_on}}) else $error("tx oe");
    chk_rx_oe_pair: assert property ({o_rx_line_pos_in_oe_n, o_rx_line_neg_in_oe_n}
        == {2{~o_rx_line_on}}) else $error("rx oe");
    chk_tx_wr_take: assert property (wr_at(ADDR_TX_ON) ##0 i_tx_line_on_master
        |=> o_tx_line_on == $past(i_wdata[5:0], 2)) else $error("tx on value");
    chk_rx_wr_take: assert property (wr_at(ADDR_RX_ON)
        |=> o_rx_line_on == $past(i_wdata[5:0], 2)) else $error("rx on value");
    chk_irq_mask: assert property (wr_at(ADDR_IRQ_MASTER)
        ##0 !(i_chan_irq & $past(i_wdata[5:0])) |=> o_irq_n) else $error("irq leak");
    chk_irq_pass: assert property (wr_at(ADDR_IRQ_MASTER)
        ##0 (i_chan_irq & $past(i_wdata[5:0])) != 6'h00 |=> !o_irq_n) else $error("irq lost");
    chk_rd_rsv: assert property (i_rd |=> o_rdata[7:6] == 2'h0) else $error("rsv bits");
    cover property (wr_at(ADDR_TX_ON) ##0 i_tx_line_on_master);
    cover property (!o_irq_n);
    cover property (i_rd && i_addr == ADDR_RX_ON);
endmodule : channel_enable_irq_gate_regs_monitor
`default_nettype wire

// ### channel_enable_irq_gate_regs_tb.sv
`default_nettype none
module channel_enable_irq_gate_regs_tb
    import liu_ctrl_pkg::*;
;
    timeunit 1ns / 1ns;
    logic       i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_tx_line_on_master = 1'b0;
    logic       o_irq_n;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, d;
    logic [5:0] ev = 6'h00, en = 6'h00, i_chan_irq, o_tx_line_on, o_rx_line_on;
    logic [5:0] o_tx_line_pos_out_oe_n, o_tx_line_neg_out_oe_n;
    logic [5:0] o_rx_line_pos_in_oe_n, o_rx_line_neg_in_oe_n;
    logic [7:0] regs [3] = '{ADDR_IRQ_MASTER, ADDR_TX_ON, ADDR_RX_ON};
    int         n_errors = 0, compares = 0, cycles = 0;
    channel_enable_irq_gate_regs i_channel_enable_irq_gate_regs (.*);
    chan_irq_source i_chan_irq_source (
        .i_event             (ev),
        .i_source_irq_enable (en),
        .o_chan_irq          (i_chan_irq)
    );
    task automatic tick;
        @(posedge i_clk);
        #1;
    endtask : tick
    // strobe dropped after its edge, so one idle cycle per write
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk) i_wr <= 1'b0;
        tick();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk) i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask : rd
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t %h %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    initial forever #25 i_clk = ~i_clk;
    always @(posedge i_clk) if (++cycles == 400) begin
        n_errors++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        tick();
        chk({o_irq_n, 1'b0, o_tx_line_pos_out_oe_n & o_rx_line_neg_in_oe_n}, 8'hbf);
        i_tx_line_on_master <= 1'b1;
        foreach (regs[i]) begin
            rd(regs[i], d);
            chk(d, 8'h00);
            wr(regs[i], 8'hff);
            rd(regs[i], d);
            chk(d, 8'h3f);
        end
        wr(ADDR_TX_ON, 8'h15);
        chk({o_tx_line_on, o_tx_line_neg_out_oe_n[1:0]}, 8'h56);
        i_tx_line_on_master <= 1'b0;
        tick();
        chk({2'h0, o_tx_line_on | ~o_tx_line_pos_out_oe_n}, 8'h00);
        wr(ADDR_RX_ON, 8'hea);
        chk({o_rx_line_on, o_rx_line_pos_in_oe_n[1:0]}, 8'ha9);
        wr(8'h61, 8'hff);
        rd(8'h61, d);
        chk(d, 8'h00);
        ev <= 6'h24;
        en <= 6'h04;
        tick();
        chk({7'h00, o_irq_n}, 8'h00);
        wr(ADDR_IRQ_MASTER, 8'hfb);
        chk({7'h00, o_irq_n}, 8'h01);
        wr(ADDR_IRQ_MASTER, 8'h04);
        chk({7'h00, o_irq_n}, 8'h00);
        final_report();
    end
endmodule : channel_enable_irq_gate_regs_tb
bind channel_enable_irq_gate_regs channel_enable_irq_gate_regs_monitor i_mon (.*);
`default_nettype wire

// ### line_gate.sv
`default_nettype none
// per-channel driver and receiver enables, tri-state controls are active low
module line_gate
    import liu_ctrl_pkg::*;
(
    input  wire logic [5:0] i_tx_on,
    input  wire logic [5:0] i_rx_on,
    input  wire logic       i_tx_master,
    output logic      [5:0] o_tx_drive,
    output logic      [5:0] o_tx_oe_n,
    output logic      [5:0] o_rx_oe_n
);
    always_comb begin
        o_tx_drive = i_tx_on & {NUM_CH{i_tx_master}};
        o_tx_oe_n  = ~o_tx_drive;
        o_rx_oe_n  = ~i_rx_on;
    end
endmodule : line_gate
`default_nettype wire

// ### liu_ctrl_pkg.sv
`default_nettype none
package liu_ctrl_pkg;
    // register map, byte addresses on the parallel port
    localparam logic [7:0] ADDR_IRQ_MASTER = 8'h60;
    localparam logic [7:0] ADDR_TX_ON      = 8'h80;
    localparam logic [7:0] ADDR_RX_ON      = 8'h88;
    // six live bits per register, bits 7:6 reserved
    localparam int         NUM_CH          = 6;
    localparam logic [5:0] FIELD_MASK      = 6'h3f;
    localparam logic [5:0] RST_TX_ON       = 6'h00;
    localparam logic [5:0] RST_RX_ON       = 6'h00;
    localparam logic [5:0] RST_IRQ_MASTER  = 6'h00;
    localparam logic [7:0] READ_UNMAPPED   = 8'h00;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_s;

    typedef struct packed {
        logic [5:0] tx_on;
        logic [5:0] rx_on;
        logic [5:0] irq_master;
    } ctrl_regs_s;
endpackage : liu_ctrl_pkg
`default_nettype wire
